/* rtl/vpcr_top.sv */
// Video processing control register with its stream path.
// Holds the disable register, the payload identifier words, pin
// synchronisers, the feature enables and the illegal code remapper.
// Assumes Avalon-MM master on clk and stream logic on the same clock.
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module vpcr_top
   import vpcr_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   // Avalon-MM register port
   input  wire logic [VPCR_ADDR_W-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   // Device pins
   input  wire logic                   processing_enable_pin,
   input  wire logic                   scrambler_bypass_pin,
   // Payload identifier built by the format detector
   input  wire logic                   pid_calc_valid,
   input  wire logic [31:0]            pid_calc_bytes,
   // Video stream in
   input  wire logic                   vin_valid,
   output logic                        vin_ready,
   input  wire vpcr_word_s             vin_word,
   // Video stream out
   output logic                        vout_valid,
   input  wire logic                   vout_ready,
   output vpcr_word_s                  vout_word,
   output logic                        h_timing_out,
   // Controls to the processing engines
   output vpcr_feat_s                  feat_en,
   output logic [1:0]                  fifo_mode,
   output logic                        ancillary_packet_insert_ctrl,
   output logic [31:0]                 pid_bytes
);

   // Register state
   logic [15:0] internal_processing_disable_q;
   logic [15:0] video_format_a_q;
   logic [15:0] video_format_b_q;
   logic [31:0] rdata_q;
   logic        ack_q;

   // Pin synchronisers
   logic [1:0]  proc_en_sync_q;
   logic [1:0]  bypass_sync_q;

   // Stream output stage
   vpcr_word_s  out_word_q;
   logic        out_valid_q;
   logic        hout_q;

   // Short name for the disable register
   wire  [15:0] dis = internal_processing_disable_q;

   // Bus decode
   wire  [7:0]  reg_idx   = avs_address[VPCR_ADDR_W-1:2];
   wire         req       = avs_read | avs_write;
   wire         done      = req & ack_q;
   wire         wr_take   = avs_write & ack_q;
   wire         sel_dis   = (reg_idx == VPCR_IDX_DISABLE);
   wire         sel_stat  = (reg_idx == VPCR_IDX_STATUS);
   wire         sel_fmt_a = (reg_idx == VPCR_IDX_FMT_A);
   wire         sel_fmt_b = (reg_idx == VPCR_IDX_FMT_B);
   wire         wr_dis    = wr_take & sel_dis;
   wire         wr_fmt_a  = wr_take & sel_fmt_a;
   wire         wr_fmt_b  = wr_take & sel_fmt_b;

   // Byte-lane write mask for the 16-bit registers
   wire  [15:0] lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire  [15:0] wdata16   = avs_writedata[15:0];

   // Synchronised pin levels
   wire         proc_en   = proc_en_sync_q[1];
   wire         bypass    = bypass_sync_q[1];
   wire         pins_ok   = proc_en & bypass;                       // see (RL10)

   // Mode fields
   wire         pid_manual = dis[VPCR_B_PID_MAN];
   wire         h_config   = dis[VPCR_B_HCFG];

   // One request takes one wait cycle, then is answered
   assign avs_waitrequest = req & ~ack_q;
   assign avs_readdata    = rdata_q;

   // Handshake: ack rises one edge after the request appears
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // Read mux; unmapped indices answer zero
   wire  [31:0] rd_mux =
        sel_dis   ? {16'h0000, dis & VPCR_DIS_MASK} :
        sel_stat  ? {24'h000000, 2'b00, feat_en} |
                    {22'h000000, pins_ok, bypass, proc_en, 7'h00} :
        sel_fmt_a ? {16'h0000, video_format_a_q} :
        sel_fmt_b ? {16'h0000, video_format_b_q} :
                    32'h00000000;

   // Read data is captured in the wait cycle and stands at the answer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read & ~ack_q) begin
         rdata_q <= rd_mux;
      end
   end

   // Disable register: plain storage cleared at reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         internal_processing_disable_q <= VPCR_DIS_RST;             // see (RL12)
      end else if (wr_dis) begin
         internal_processing_disable_q <=
            ((dis & ~lane_mask) | (wdata16 & lane_mask)) & VPCR_DIS_MASK; // see (RL12)
      end
   end

   // Payload words: hardware copy wins over a software write in auto mode,
   // so a generated packet is never lost to a colliding write
   wire         hw_load  = pid_calc_valid & ~pid_manual;              // see (RL14)

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         video_format_a_q <= VPCR_FMT_RST;
         video_format_b_q <= VPCR_FMT_RST;
      end else if (hw_load) begin
         video_format_a_q <= pid_calc_bytes[15:0];                   // see (RL14)
         video_format_b_q <= pid_calc_bytes[31:16];                  // see (RL14)
      end else begin
         if (wr_fmt_a) video_format_a_q <= (video_format_a_q & ~lane_mask) |
                                           (wdata16 & lane_mask); // see (RL4)
         if (wr_fmt_b) video_format_b_q <= (video_format_b_q & ~lane_mask) |
                                           (wdata16 & lane_mask); // see (RL4)
      end
   end

   // Two-flop synchronisers for the asynchronous pins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         proc_en_sync_q <= 2'b00;
         bypass_sync_q  <= 2'b00;
      end else begin
         proc_en_sync_q <= {proc_en_sync_q[0], processing_enable_pin};
         bypass_sync_q  <= {bypass_sync_q[0], scrambler_bypass_pin};
      end
   end

   // Feature enables: each except pid_auto needs both pins high and its own bit low
   assign feat_en.timing_ref_insert_disable  = pins_ok & ~dis[VPCR_B_TRS];             // see (RL9)
   assign feat_en.csum_ins = pins_ok & ~dis[VPCR_B_CSUM];            // see (RL8)
   assign feat_en.edh_ins  = pins_ok & ~dis[VPCR_B_EDH];             // see (RL7)
   assign feat_en.remap    = pins_ok & ~dis[VPCR_B_REMAP];           // see (RL6)
   assign feat_en.pid_ins  = pins_ok & ~dis[VPCR_B_PID_INS];         // see (RL5)
   assign feat_en.pid_auto = ~pid_manual;                            // see (RL3)

   // Line FIFO mode goes straight to the FIFO controller
   assign fifo_mode = dis[VPCR_B_FIFO_LO+1:VPCR_B_FIFO_LO];          // see (RL1)

   // Stored only; the ancillary inserter also looks at its own conditions,
   // so a low level here does not by itself stop insertion
   assign ancillary_packet_insert_ctrl = dis[VPCR_B_ANC_PKT];         // see (RL11)

   // Packet to insert: built words in auto mode, software words otherwise
   assign pid_bytes = {video_format_b_q, video_format_a_q};          // see (RL3)

   // Stream buffer between the input and the remap stage
   logic        fifo_valid;
   logic        fifo_ready;
   vpcr_word_s  fifo_word;

   vpcr_fifo #(
      .WIDTH (VPCR_WORD_W),
      .DEPTH (VPCR_FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rstn     (rstn),
      .wr_valid (vin_valid),
      .wr_ready (vin_ready),
      .wr_data  (vin_word),
      .rd_valid (fifo_valid),
      .rd_ready (fifo_ready),
      .rd_data  (fifo_word)
   );

   // Output stage accepts when empty or being drained; vout_ready
   // stalls this stage, which in turn lets the FIFO fill
   assign fifo_ready = ~out_valid_q | vout_ready;
   wire         take_word = fifo_valid & fifo_ready;

   // Illegal code detection inside active picture
   wire  [9:0]  din      = fifo_word.data;
   wire         code_hi  = (din >= VPCR_CODE_HI_MIN);
   wire         code_lo  = (din <= VPCR_CODE_LO_MAX);
   wire         do_remap = feat_en.remap & fifo_word.active;          // see (RL6)
   wire  [9:0]  dout     = (do_remap & code_hi) ? VPCR_CODE_HI_REP :  // see (RL13)
                           (do_remap & code_lo) ? VPCR_CODE_LO_REP :  // see (RL13)
                                                  din;

   // Horizontal timing source select
   wire         h_sel    = h_config ? fifo_word.trs_h
                                    : fifo_word.line_blank;          // see (RL2)

   // Output word register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_word_q <= '0;
         hout_q     <= 1'b0;
      end else if (take_word) begin
         out_word_q            <= fifo_word;
         out_word_q.data       <= dout;
         hout_q                <= h_sel;                              // see (RL2)
      end
   end

   // Output valid flag
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_valid_q <= 1'b0;
      end else if (fifo_ready) begin
         out_valid_q <= fifo_valid;
      end
   end

   assign vout_valid   = out_valid_q;
   assign vout_word    = out_word_q;
   assign h_timing_out = hout_q;

endmodule

/* rtl/vpcr_pkg.sv */
// Package of constants and carrier types for the video processing control block.
// Assumes a single 200 MHz clock domain and an Avalon-MM slave register port.
// Overview of operation
// (RL1) Bits 8-7 choose the line FIFO mode.
// (RL2) Bit 6 picks the horizontal timing output source.
// (RL3) Bit 5 low: device builds payload packet itself.
// (RL4) Bit 5 high: software writes payload packet words.
// (RL5) Bit 4 high stops payload packet insertion.
// (RL6) Bit 3 high stops illegal code correction.
// (RL7) Bit 2 high stops error check packet generation.
// (RL8) Bit 1 high stops ancillary checksum insertion.
// (RL9) Bit 0 high stops timing reference insertion.
// (RL10) Features need both pins high plus bit low.
// (RL11) Ancillary insert control alone never stops insertion.
// (RL12) Fields are plain storage, reset to zero.
// (RL13) Remap 3FC-3FF to 3FB, 000-003 to 004.
// (RL14) Auto mode writes built packet back to registers.
package vpcr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  VPCR_IDX_DISABLE = 8'h01;
   localparam logic [7:0]  VPCR_IDX_STATUS  = 8'h02;
   localparam logic [7:0]  VPCR_IDX_FMT_A   = 8'h0F;
   localparam logic [7:0]  VPCR_IDX_FMT_B   = 8'h10;
   localparam int          VPCR_ADDR_W      = 10;

   // Field positions of the processing disable register
   localparam int          VPCR_B_TRS       = 0;
   localparam int          VPCR_B_CSUM      = 1;
   localparam int          VPCR_B_EDH       = 2;
   localparam int          VPCR_B_REMAP     = 3;
   localparam int          VPCR_B_PID_INS   = 4;
   localparam int          VPCR_B_PID_MAN   = 5;
   localparam int          VPCR_B_HCFG      = 6;
   localparam int          VPCR_B_FIFO_LO   = 7;
   localparam int          VPCR_B_ANC_PKT   = 9;
   localparam logic [15:0] VPCR_DIS_MASK    = 16'h03FF;

   // Values after reset
   localparam logic [15:0] VPCR_DIS_RST     = 16'h0000;
   localparam logic [15:0] VPCR_FMT_RST     = 16'h0000;

   // Illegal code limits and replacements
   localparam logic [9:0]  VPCR_CODE_HI_MIN = 10'h3FC;
   localparam logic [9:0]  VPCR_CODE_HI_REP = 10'h3FB;
   localparam logic [9:0]  VPCR_CODE_LO_MAX = 10'h003;
   localparam logic [9:0]  VPCR_CODE_LO_REP = 10'h004;

   // Stream FIFO shape
   localparam int          VPCR_FIFO_DEPTH  = 8;

   // Video word with its timing flags
   typedef struct packed {
      logic [9:0] data;
      logic       active;   // Inside active picture
      logic       trs_h;    // H bit carried by the last TRS word
      logic       line_blank; // Active-line blanking timing
   } vpcr_word_s;

   localparam int          VPCR_WORD_W      = $bits(vpcr_word_s);

   // Per-feature enables handed to the processing engines
   typedef struct packed {
      logic timing_ref_insert_disable;
      logic csum_ins;
      logic edh_ins;
      logic remap;
      logic pid_ins;
      logic pid_auto;
   } vpcr_feat_s;

endpackage

/* rtl/vpcr_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; depth is a power of two.
`timescale 1ns/10ps
module vpcr_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Fill side
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   input  wire logic [WIDTH-1:0] wr_data,
   // Drain side
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic [WIDTH-1:0]      rd_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wptr_q;
   logic [AW-1:0]    rptr_q;
   logic [AW:0]      cnt_q;
   wire              push = wr_valid & wr_ready;
   wire              pop  = rd_valid & rd_ready;

   // Honest flags straight from the occupancy count
   assign wr_ready = (cnt_q != (AW+1)'(DEPTH));
   assign rd_valid = (cnt_q != '0);
   assign rd_data  = mem_q[rptr_q];

   // Storage has no reset; only pointers and count need a defined value
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wptr_q] <= wr_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end else begin
         if (push) wptr_q <= wptr_q + 1'b1;
         if (pop)  rptr_q <= rptr_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

/* tb/vpcr_assertions.sv */
// Checker for the video processing control block, bound to vpcr_top.
// Sees only top module ports; one clock, reset active low.
`timescale 1ns/10ps
module vpcr_checker
   import vpcr_pkg::*;
(
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   rstn,
   // Register port
   input wire logic [VPCR_ADDR_W-1:0] avs_address,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [31:0]            avs_writedata,
   input wire logic [3:0]             avs_byteenable,
   input wire logic                   avs_waitrequest,
   // Pins and stream
   input wire logic                   processing_enable_pin,
   input wire logic                   scrambler_bypass_pin,
   input wire logic                   pid_calc_valid,
   input wire logic [31:0]            pid_calc_bytes,
   input wire logic                   vout_valid,
   input wire logic                   vout_ready,
   input wire vpcr_word_s             vout_word,
   // Controls
   input wire vpcr_feat_s             feat_en,
   input wire logic [1:0]             fifo_mode,
   input wire logic                   ancillary_packet_insert_ctrl,
   input wire logic [31:0]            pid_bytes
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Full write of the disable register at its answer edge
   wire dis_wr = avs_write && !avs_waitrequest && avs_address[9:2] == VPCR_IDX_DISABLE
      && avs_byteenable[1:0] == 2'b11;
   logic [15:0] wd_q;

   // Keeps the written value so later cycles can be compared with it
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         wd_q <= '0;
      else if (dis_wr)
         wd_q <= avs_writedata[15:0];

   sequence s_dis_wr;
      dis_wr ##1 1'b1;
   endsequence

   a_fifo_mode_field: assert property (s_dis_wr |-> fifo_mode == wd_q[8:7])
      else $error("fifo mode differs from written field");
   a_anc_ctrl_bit: assert property (s_dis_wr |-> ancillary_packet_insert_ctrl == wd_q[9])
      else $error("ancillary control differs from written bit");
   a_pid_auto_sel: assert property (s_dis_wr |-> feat_en.pid_auto == !wd_q[5])
      else $error("payload auto select wrong");
   a_pid_ins_off: assert property (s_dis_wr ##0 wd_q[4] |-> !feat_en.pid_ins)
      else $error("payload insert still on");
   a_remap_off: assert property (s_dis_wr ##0 wd_q[3] |-> !feat_en.remap)
      else $error("remap still on");
   a_edh_off: assert property (s_dis_wr ##0 wd_q[2] |-> !feat_en.edh_ins)
      else $error("error check packet still on");
   a_csum_off: assert property (s_dis_wr ##0 wd_q[1] |-> !feat_en.csum_ins)
      else $error("checksum insert still on");
   a_trs_off: assert property (s_dis_wr ##0 wd_q[0] |-> !feat_en.timing_ref_insert_disable)
      else $error("timing reference insert still on");
   a_pin_gate: assert property ((|feat_en[5:1]) |->
      $past(processing_enable_pin, 2) && $past(scrambler_bypass_pin, 2))
      else $error("feature on without both pins high");
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("register answer late");
   // Only judged while remap has been steady, since words in flight may predate a change
   a_remap_range: assert property (vout_valid && vout_word.active && feat_en.remap
      && $past(feat_en.remap) && $past(feat_en.remap, 2)
      |-> vout_word.data inside {[10'h004:10'h3FB]})
      else $error("illegal code left in active picture");
   a_out_hold: assert property (vout_valid && !vout_ready |=> vout_valid && $stable(vout_word))
      else $error("output word changed while stalled");
   a_pid_writeback: assert property (pid_calc_valid && feat_en.pid_auto
      |=> pid_bytes == $past(pid_calc_bytes))
      else $error("generated packet not written back");
   a_manual_keep: assert property (pid_calc_valid && !feat_en.pid_auto && !avs_write
      |=> $stable(pid_bytes))
      else $error("manual packet overwritten");
endmodule

bind vpcr_top vpcr_checker i_chk (.clk, .rstn, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_waitrequest, .processing_enable_pin,
   .scrambler_bypass_pin, .pid_calc_valid, .pid_calc_bytes, .vout_valid, .vout_ready,
   .vout_word, .feat_en, .fifo_mode, .ancillary_packet_insert_ctrl, .pid_bytes);

/* tb/testbench.sv */
// Self-checking bench for the video processing control block.
// Drives every vpcr_top input itself; the checker is bound in its own file.
`timescale 1ns/10ps
module testbench;
   import vpcr_pkg::*;
   logic                   clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
   logic [VPCR_ADDR_W-1:0] avs_address = '0;
   logic [31:0]            avs_writedata = '0, avs_readdata, pid_calc_bytes = '0, pid_bytes, q;
   logic [3:0]             avs_byteenable = 4'hF;
   logic                   avs_waitrequest, processing_enable_pin = 1, scrambler_bypass_pin = 1;
   logic                   pid_calc_valid = 0, vin_valid = 0, vin_ready, vout_valid;
   logic                   vout_ready = 1, h_timing_out, ancillary_packet_insert_ctrl;
   vpcr_word_s             vin_word = '0, vout_word;
   vpcr_feat_s             feat_en;
   logic [1:0]             fifo_mode;
   int                     error_cnt = 0, comparisons = 0, cyc = 0, n;
   logic [9:0]             din[7] = '{10'h3FC, 10'h3FF, 10'h000, 10'h003, 10'h004, 10'h3FB, 10'h3FF};
   logic [9:0]             dout[7] = '{10'h3FB, 10'h3FB, 10'h004, 10'h004, 10'h004, 10'h3FB, 10'h3FF};

   always #2.5 clk = ~clk;

   vpcr_top i_dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .processing_enable_pin,
      .scrambler_bypass_pin, .pid_calc_valid, .pid_calc_bytes, .vin_valid, .vin_ready,
      .vin_word, .vout_valid, .vout_ready, .vout_word, .h_timing_out, .feat_en, .fifo_mode,
      .ancillary_packet_insert_ctrl, .pid_bytes);

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One Avalon access; held until waitrequest is seen low at a rising edge
   task automatic bus(logic wr, logic [7:0] idx, logic [31:0] d);
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      @(negedge clk);
   endtask

   task automatic rd(logic [7:0] idx, logic [31:0] e, string nm);
      bus(0, idx, '0);
      chk(nm, e, q);
   endtask

   // Expected enables with all pins combined into g
   function automatic logic [5:0] ef(logic [15:0] r, logic g);
      return {~r[0] & g, ~r[1] & g, ~r[2] & g, ~r[3] & g, ~r[4] & g, ~r[5]};
   endfunction

   task automatic pulse(logic [31:0] b);
      @(posedge clk);
      pid_calc_valid <= 1;
      pid_calc_bytes <= b;
      @(posedge clk);
      pid_calc_valid <= 0;
      @(negedge clk);
   endtask

   // Sends one word and checks it at the output before it is taken
   task automatic xfer(vpcr_word_s w, logic [9:0] ed, logic eh);
      @(posedge clk);
      vin_valid <= 1;
      vin_word <= w;
      do @(posedge clk); while (vin_ready !== 1'b1);
      vin_valid <= 0;
      do @(negedge clk); while (vout_valid !== 1'b1);
      chk("out data", ed, vout_word.data);
      chk("h timing", eh, h_timing_out);
      @(posedge clk);
   endtask

   task automatic report_and_stop();
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Cuts a hang short; the whole run needs well under this
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1;
      rd(VPCR_IDX_DISABLE, 0, "dis reset");
      rd(VPCR_IDX_FMT_A, 0, "fmt a reset");
      rd(VPCR_IDX_FMT_B, 0, "fmt b reset");
      rd(8'h3F, 0, "unmapped");
      // One bit at a time, bit 10 being unused; upper write bits must not stick
      for (int i = 0; i < 11; i++) begin
         bus(1, VPCR_IDX_DISABLE, 32'hFFFF0000 | (1 << i));
         rd(VPCR_IDX_DISABLE, (1 << i) & 32'h3FF, "dis readback");
         chk("feat", ef(16'(1 << i), 1), feat_en);
         chk("fifo mode", ((1 << i) >> 7) & 3, fifo_mode);
         chk("anc ctrl", i == 9, ancillary_packet_insert_ctrl);
      end
      // Upper lane only must leave the lower byte alone; unmapped writes vanish
      @(posedge clk);
      avs_byteenable <= 4'h2;
      bus(1, VPCR_IDX_DISABLE, 32'hFFFF);
      bus(1, 8'h3F, 32'hFFFF);
      rd(VPCR_IDX_DISABLE, 32'h0300, "upper lane");
      rd(8'h3F, 0, "unmapped write");
      @(posedge clk);
      avs_byteenable <= 4'hF;
      bus(1, VPCR_IDX_DISABLE, 0);
      // Every pin combination; only both high lets features run
      for (int p = 0; p < 4; p++) begin
         @(posedge clk);
         processing_enable_pin <= p[0];
         scrambler_bypass_pin <= p[1];
         repeat (3) @(posedge clk);
         rd(VPCR_IDX_STATUS, {p[0] & p[1], p[1], p[0], 1'b0, ef(0, p[0] & p[1])}, "st");
         chk("feat pins", ef(0, p[0] & p[1]), feat_en);
      end
      bus(1, VPCR_IDX_DISABLE, 32'h20);
      bus(1, VPCR_IDX_FMT_A, 32'h1234);
      bus(1, VPCR_IDX_FMT_B, 32'h5678);
      pulse(32'hA1B2C3D4);
      chk("pid manual", 32'h56781234, pid_bytes);
      bus(1, VPCR_IDX_DISABLE, 0);
      pulse(32'hA1B2C3D4);
      rd(VPCR_IDX_FMT_A, 32'hC3D4, "fmt a auto");
      rd(VPCR_IDX_FMT_B, 32'hA1B2, "fmt b auto");
      // Remap on with line blanking timing, then remap off with TRS timing
      for (int p = 0; p < 2; p++) begin
         bus(1, VPCR_IDX_DISABLE, p ? 32'h48 : 32'h0);
         for (int i = 0; i < 7; i++)
            xfer({din[i], i < 6, 2'b10}, p ? din[i] : dout[i], p[0]);
      end
      // Stall the sink, fill until refused, then drain in order
      @(posedge clk);
      vout_ready <= 0;
      vin_valid <= 1;
      vin_word <= '0;
      n = 0;
      repeat (20) begin
         @(posedge clk);
         if (vin_ready) begin
            n++;
            vin_word <= {10'(n), 3'b000};
         end
      end
      vin_valid <= 0;
      vout_ready <= 1;
      chk("fill count", 9, n);
      for (int k = 0; k < 9; k++) begin
         do @(negedge clk); while (vout_valid !== 1'b1);
         chk("drain order", k, vout_word.data);
         @(posedge clk);
      end
      repeat (3) @(negedge clk);
      chk("empty", 0, vout_valid);
      // A reset in mid-run must clear stored fields again
      bus(1, VPCR_IDX_DISABLE, 32'h3FF);
      @(posedge clk);
      rstn <= 0;
      repeat (2) @(posedge clk);
      rstn <= 1;
      rd(VPCR_IDX_DISABLE, 0, "dis rerun");
      rd(VPCR_IDX_FMT_A, 0, "fmt a rerun");
      chk("feat rerun", ef(0, 1), feat_en);
      report_and_stop();
   end
endmodule
